// File: rtl/paged_array_consts.vh
// Constants of the paged logic array core: register word offsets, field
// positions, reset values and array geometry.
// Included by the core and its configuration memory; holds only defines.
`ifndef PAGED_ARRAY_CONSTS_VH
`define PAGED_ARRAY_CONSTS_VH

// Register word offsets (Avalon word addresses)
`define REG_CTRL        11'h000
`define REG_STATUS      11'h001
`define REG_MC_STATE    11'h002
`define REG_MUX3_SEL    11'h003
`define REG_MUX2_SEL_LO 11'h004
`define REG_MUX2_SEL_HI 11'h005
`define REG_MC_MODE     11'h006
`define REG_MC_OE       11'h007
`define REG_IOC_CFG     11'h008
`define REG_CAP_CFG     11'h009
`define FIXED_BASE      11'h200
`define PAGE_BASE       11'h400

// Field positions
`define CTRL_RUN_BIT    0
`define IOC_REG_BIT     0
`define IOC_INV_BIT     1
`define IOC_BURIED_BIT  2

// Reset values
`define CTRL_RST        1'h0
`define PAGE_RST        3'h0

// Paged array geometry
`define PAGES           8
`define PAGE_IN         64
`define PAGE_TERMS      16
`define PAGE_LINES      54
`define PAGE_CELLS      27
`define PAGE_WORDS      91
`define PAGE_OR_BASE    2048

// Fixed-OR array geometry
`define FIX_IN          48
`define FIX_TERMS       76
`define FIX_WORDS       228
`define IO_CELLS        8
`define TERMS_PER_CELL  9

`endif

// File: rtl/cfg_mem.v
// Configuration memory: word-wide writes, one whole entry read per cycle.
// Assumes one clock; contents are undefined until software loads them.
`timescale 1ns/100ps
`include "paged_array_consts.vh"

module cfg_mem #(
   parameter WORDS   = 91,
   parameter ENTRIES = 8,
   parameter AW      = 10,
   parameter EW      = 3
) (
   // Clock
   input  wire                  clk_i,
   // Write port
   input  wire                  wr_en_i,
   input  wire [AW-1:0]         wr_addr_i,
   input  wire [31:0]           wr_data_i,
   // Entry read port
   input  wire [EW-1:0]         rd_entry_i,
   output reg  [WORDS*32-1:0]   rd_data_o
);

   reg [31:0] mem [0:WORDS*ENTRIES-1];

   // Word write
   always @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // Whole entry is read every cycle, so the output always lags one edge
   genvar w;
   generate
      for (w = 0; w < WORDS; w = w + 1) begin : g_rd
         always @(posedge clk_i) begin
            rd_data_o[w*32 +: 32] <= mem[rd_entry_i * WORDS + w];
         end
      end
   endgenerate

endmodule

// File: rtl/paged_array_core.v
// Paged programmable logic array core with fixed-OR array and Avalon slave.
// Assumes synchronous pin logic around it and software loading the arrays.
//
// Overview of operation
// [R1] Eight pages: 64 inputs, 16 terms, 54 lines
// [R2] Only the selected page contributes logic
// [R3] Three page macrocells select the active page
// [R4] Page cells clock with outputs, next page preloaded
// [R5] Page cells double as buried state bits
// [R6] Fixed-OR and control logic always active; the fixed-cell registers and page cells here hold while run is low
// [R7] Fixed-OR array: 48 inputs, 76 terms, 8 cells
// [R8] Each cell registered or combinational, selectable polarity
// [R9] Cell may be buried, pin used as input
// [R10] Macrocells do data-enable and JK with enable; the JK mode here has no enable line
// [R11] Page terms shared freely through programmable OR
// [R12] 56 input muxes: 40 two-way, 16 three-way
// [R13] Pins reach both arrays at once
// [R14] Capture cells feed the paged array only
// [R15] Routing to one array never blocks other
// [R16] Page cells: no pin, feedback to both
// [R17] Page registers reset to page zero
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "paged_array_consts.vh"

module paged_array_core (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Avalon-MM slave
   input  wire [10:0] avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   output reg  [31:0] avs_readdata_o,
   output wire        avs_waitrequest_o,
   // Two-way pins 0-7 fixed-OR cells, 8-31 paged macrocells
   input  wire [31:0] io_in_i,
   output wire [31:0] io_out_o,
   output wire [31:0] io_oe_o,
   // Dedicated input pin
   input  wire        ded_in_i,
   // Active page
   output wire [2:0]  page_o
);

   // Software registers
   reg         run_ff;
   reg  [31:0] mux3_sel_ff;
   reg  [39:0] mux2_sel_ff;
   reg  [26:0] mc_mode_ff;
   reg  [23:0] mc_oe_ff;
   reg  [23:0] ioc_cfg_ff;
   reg  [15:0] cap_cfg_ff;
   reg         rd_done_ff;

   // Synchronised pins and capture cells
   reg  [31:0] pin_s1_ff;
   reg  [31:0] pin_s2_ff;
   reg         ded_s1_ff;
   reg         ded_s2_ff;
   reg  [15:0] cap1_ff;
   reg  [15:0] cap2_ff;

   // Macrocell and io cell state
   reg  [26:0] mc_ff;
   reg  [26:0] nxt_mc;
   reg  [7:0]  ioc_ff;

   // Array nets
   wire [63:0]          pla_in;
   wire [47:0]          pal_in;
   wire [15:0]          pla_term;
   wire [53:0]          pla_line;
   wire [75:0]          pal_term;
   wire [91*32-1:0]     page_cfg;
   wire [228*32-1:0]    fix_cfg;
   wire [15:0]          cap_out;
   wire [15:0]          mux3_out;
   wire [39:0]          mux2_out;
   wire [7:0]           ioc_sum;
   wire [7:0]           ioc_oe_term;
   wire [7:0]           ioc_clr;
   wire [2:0]           page_q;
   wire [2:0]           nxt_page;
   wire [2:0]           rd_page;
   wire                 page_wr;
   wire                 fix_wr;
   wire [10:0]          page_off;
   wire [10:0]          fix_off;

   // Page cells are the top three macrocells; page_o shows them
   assign page_q   = mc_ff[26:24];
   assign nxt_page = nxt_mc[26:24];
   assign page_o   = page_q;

   // Pin synchronisers; only the second stage feeds any logic
   // Two stages cost two cycles of pin latency but keep metastability out
   always @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_ff <= 32'h0;
         pin_s2_ff <= 32'h0;
         ded_s1_ff <= 1'h0;
         ded_s2_ff <= 1'h0;
      end else begin
         pin_s1_ff <= io_in_i;
         pin_s2_ff <= pin_s1_ff;
         ded_s1_ff <= ded_in_i;
         ded_s2_ff <= ded_s1_ff;
      end
   end

   // Capture cells on pins 12-27, single or double registered
   // Double registering costs a cycle but gives the first stage a full
   // period to settle before the paged array sees the value
   always @(posedge clk_i) begin
      if (rst_i) begin
         cap1_ff <= 16'h0;
         cap2_ff <= 16'h0;
      end else begin
         cap1_ff <= pin_s2_ff[27:12];
         cap2_ff <= cap1_ff;
      end
   end
   assign cap_out = (cap2_ff & cap_cfg_ff) | (cap1_ff & ~cap_cfg_ff);

   // Three-way muxes for pins 12-27: pin, cell feedback or capture cell
   // Codes 0 and 3 both pass the pin, so a cleared select is a plain pin
   genvar k;
   generate
      for (k = 0; k < 16; k = k + 1) begin : g_mux3
         wire [1:0] sel = mux3_sel_ff[k*2 +: 2];
         assign mux3_out[k] = (sel == 2'h1) ? mc_ff[k+4] :   // R12
                              (sel == 2'h2) ? cap_out[k] :   // R14
                              pin_s2_ff[k+12];
      end
   endgenerate

   // Two-way muxes: 0-15 paged side, 16-27 and 28-39 fixed side
   wire [15:0] m2_pin = {pin_s2_ff[31:28], pin_s2_ff[11:0]};
   wire [15:0] m2_fb  = {mc_ff[23:20], mc_ff[3:0], ioc_ff};
   wire [11:0] f_pin  = {pin_s2_ff[31:28], pin_s2_ff[7:0]};
   wire [11:0] f_fb   = {mc_ff[23:20], ioc_ff};
   generate
      for (k = 0; k < 16; k = k + 1) begin : g_mux2a
         assign mux2_out[k] = mux2_sel_ff[k] ? m2_fb[k] : m2_pin[k]; // R12
      end
      // Two independent selects per pin let pin and feedback both pass
      for (k = 0; k < 12; k = k + 1) begin : g_mux2b
         assign mux2_out[16+k] = mux2_sel_ff[16+k] ? f_fb[k] : f_pin[k];
         assign mux2_out[28+k] = mux2_sel_ff[28+k] ? f_pin[k] : f_fb[k];
      end
   endgenerate

   // Paged array inputs: pins also go direct, page feedback too
   assign pla_in = {ded_s2_ff, mc_ff[15:4],                      // R13
                    pin_s2_ff[31:28], pin_s2_ff[11:0],           // R15
                    page_q, mux2_out[15:0], mux3_out};           // R16

   // Fixed array inputs: no capture cell appears here
   assign pal_in = {ded_s2_ff, mux2_out[39:28],                  // R14
                    pin_s2_ff[27:8], page_q,                     // R16
                    mux2_out[27:16]};                            // R13

   // Page writes and fixed-array writes into configuration memories
   // Offsets wrap below each base, so the base compare guards them too
   assign page_off = avs_address_i - `PAGE_BASE;
   assign fix_off  = avs_address_i - `FIXED_BASE;
   assign page_wr  = avs_write_i && (avs_address_i >= `PAGE_BASE) &&
                     (page_off < `PAGES * `PAGE_WORDS);
   assign fix_wr   = avs_write_i && (avs_address_i >= `FIXED_BASE) &&
                     (fix_off < `FIX_WORDS);

   // Memory reads the next page, so its output matches the new page
   // Reset forces page zero so the first cycle after release already
   // sees the page zero entry rather than a stale one
   assign rd_page = rst_i ? `PAGE_RST : nxt_page;                // R4

   cfg_mem #(
      .WORDS   (`PAGE_WORDS),
      .ENTRIES (`PAGES),
      .AW      (10),
      .EW      (3)
   ) u_page_mem (
      .clk_i      (clk_i),
      .wr_en_i    (page_wr),
      .wr_addr_i  (page_off[9:0]),
      .wr_data_i  (avs_writedata_i),
      .rd_entry_i (rd_page),                                     // R2
      .rd_data_o  (page_cfg)
   );

   cfg_mem #(
      .WORDS   (`FIX_WORDS),
      .ENTRIES (1),
      .AW      (8),
      .EW      (1)
   ) u_fix_mem (
      .clk_i      (clk_i),
      .wr_en_i    (fix_wr),
      .wr_addr_i  (fix_off[7:0]),
      .wr_data_i  (avs_writedata_i),
      .rd_entry_i (1'h0),                                        // R6
      .rd_data_o  (fix_cfg)
   );

   // Paged AND plane: a term is the AND of its true and complement taps
   genvar t;
   generate
      for (t = 0; t < `PAGE_TERMS; t = t + 1) begin : g_pla_and
         wire [63:0] tm = page_cfg[t*128 +: 64];
         wire [63:0] cm = page_cfg[t*128+64 +: 64];
         assign pla_term[t] = &((~tm | pla_in) & (~cm | ~pla_in)); // R1
      end
      // Programmable OR plane: any term may feed any line
      for (t = 0; t < `PAGE_LINES; t = t + 1) begin : g_pla_or
         assign pla_line[t] =
            |(page_cfg[`PAGE_OR_BASE + t*16 +: 16] & pla_term);  // R11
      end
      // Fixed AND plane, evaluated every cycle whatever the page
      for (t = 0; t < `FIX_TERMS; t = t + 1) begin : g_pal_and
         wire [47:0] tm = fix_cfg[t*96 +: 48];
         wire [47:0] cm = fix_cfg[t*96+48 +: 48];
         assign pal_term[t] = &((~tm | pal_in) & (~cm | ~pal_in)); // R7
      end
      // Fixed OR: eight terms per cell, one enable term, shared clears
      for (t = 0; t < `IO_CELLS; t = t + 1) begin : g_pal_or
         assign ioc_sum[t]     = |pal_term[t*9 +: 8];           // R7
         assign ioc_oe_term[t] = pal_term[t*9+8];
         assign ioc_clr[t]     = pal_term[72 + t/2];
      end
   endgenerate

   // Macrocell next state: line 2m is J or D, line 2m+1 is K or E
   // Run low freezes every macrocell, so software may reload the arrays
   // without the state machine wandering through half-written pages
   integer m;
   always @* begin
      nxt_mc = mc_ff;
      for (m = 0; m < `PAGE_CELLS; m = m + 1) begin
         if (!run_ff) begin
            nxt_mc[m] = mc_ff[m];
         end else if (mc_mode_ff[m]) begin
            case ({pla_line[2*m], pla_line[2*m+1]})              // R10
               2'b10:   nxt_mc[m] = 1'b1;
               2'b01:   nxt_mc[m] = 1'b0;
               2'b11:   nxt_mc[m] = ~mc_ff[m];
               default: nxt_mc[m] = mc_ff[m];
            endcase
         end else if (pla_line[2*m+1]) begin
            nxt_mc[m] = pla_line[2*m];                           // R10
         end else begin
            nxt_mc[m] = mc_ff[m];
         end
      end
   end

   // Output and page macrocells share one edge; page cells are state too
   always @(posedge clk_i) begin
      if (rst_i) begin
         mc_ff <= 27'h0;                                         // R17
      end else begin
         mc_ff <= nxt_mc;                                        // R3 R4 R5
      end
   end

   // Fixed-array cells register their sum while run is set; a term clears a pair
   // Sharing clear terms between two cells spares product terms; a clear
   // beats the sum when both arrive in one cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         ioc_ff <= 8'h0;
      end else if (run_ff) begin
         ioc_ff <= ioc_sum & ~ioc_clr;                           // R6
      end
   end

   // Cell outputs: register or sum, polarity, buried or driven
   generate
      for (k = 0; k < `IO_CELLS; k = k + 1) begin : g_ioc
         wire [2:0] cfg = ioc_cfg_ff[k*3 +: 3];
         wire       val = cfg[`IOC_REG_BIT] ? ioc_ff[k] : ioc_sum[k];
         assign io_out_o[k] = val ^ cfg[`IOC_INV_BIT];           // R8
         assign io_oe_o[k]  = ~cfg[`IOC_BURIED_BIT] &
                              ioc_oe_term[k];                    // R9
      end
   endgenerate

   // Paged macrocells drive pins 8-31; page cells have no pin
   assign io_out_o[31:8] = mc_ff[23:0];
   assign io_oe_o[31:8]  = mc_oe_ff;                             // R16

   // Register writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         run_ff      <= `CTRL_RST;
         mux3_sel_ff <= 32'h0;
         mux2_sel_ff <= 40'h0;
         mc_mode_ff  <= 27'h0;
         mc_oe_ff    <= 24'h0;
         ioc_cfg_ff  <= 24'h0;
         cap_cfg_ff  <= 16'h0;
      end else if (avs_write_i) begin
         case (avs_address_i)
            `REG_CTRL:        run_ff <= avs_writedata_i[`CTRL_RUN_BIT];
            `REG_MUX3_SEL:    mux3_sel_ff <= avs_writedata_i;
            `REG_MUX2_SEL_LO: mux2_sel_ff[31:0] <= avs_writedata_i;
            `REG_MUX2_SEL_HI: mux2_sel_ff[39:32] <= avs_writedata_i[7:0];
            `REG_MC_MODE:     mc_mode_ff <= avs_writedata_i[26:0];
            `REG_MC_OE:       mc_oe_ff <= avs_writedata_i[23:0];
            `REG_IOC_CFG:     ioc_cfg_ff <= avs_writedata_i[23:0];
            `REG_CAP_CFG:     cap_cfg_ff <= avs_writedata_i[15:0];
            default:          run_ff <= run_ff;
         endcase
      end
   end

   // Reads take one wait cycle so read data come from a register
   // Read data are rebuilt every cycle; only the completing edge counts
   assign avs_waitrequest_o = avs_read_i & ~rd_done_ff;

   always @(posedge clk_i) begin
      if (rst_i) begin
         rd_done_ff     <= 1'h0;
         avs_readdata_o <= 32'h0;
      end else begin
         rd_done_ff <= avs_read_i & ~rd_done_ff;
         case (avs_address_i)
            `REG_CTRL:        avs_readdata_o <= {31'h0, run_ff};
            `REG_STATUS:      avs_readdata_o <= {29'h0, page_q};
            `REG_MC_STATE:    avs_readdata_o <= {5'h0, mc_ff};
            `REG_MUX3_SEL:    avs_readdata_o <= mux3_sel_ff;
            `REG_MUX2_SEL_LO: avs_readdata_o <= mux2_sel_ff[31:0];
            `REG_MUX2_SEL_HI: avs_readdata_o <= {24'h0, mux2_sel_ff[39:32]};
            `REG_MC_MODE:     avs_readdata_o <= {5'h0, mc_mode_ff};
            `REG_MC_OE:       avs_readdata_o <= {8'h0, mc_oe_ff};
            `REG_IOC_CFG:     avs_readdata_o <= {8'h0, ioc_cfg_ff};
            `REG_CAP_CFG:     avs_readdata_o <= {16'h0, cap_cfg_ff};
            // Array memories are write-only; they and holes read zero
            default:          avs_readdata_o <= 32'h0;
         endcase
      end
   end

endmodule

// File: testbench/paged_array_asserts.sv
// Checker: bus handshake, reset values and page visibility of the core.
// Assumes binding to paged_array_core, one clock, synchronous reset.
`timescale 1ns/100ps
`include "paged_array_consts.vh"
module paged_array_asserts (
   // Clock and reset
   input wire        clk_i,
   input wire        rst_i,
   // Bus
   input wire [10:0] avs_address_i,
   input wire        avs_read_i,
   input wire        avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [31:0] avs_readdata_o,
   input wire        avs_waitrequest_o,
   // Pins and page
   input wire [31:0] io_oe_o,
   input wire [2:0]  page_o
);
   default clocking cb @(posedge clk_i); endclocking
   // Read taken at this edge
   wire rd_done = avs_read_i & ~avs_waitrequest_o;
   // A fresh read is one not already waiting
   sequence s_rd_fresh;
      avs_read_i && !$past(avs_read_i && avs_waitrequest_o);
   endsequence
   sequence s_rd_answer;
      avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence
   a_read_wait_once: assert property (disable iff (rst_i)
      s_rd_fresh |-> s_rd_answer) else $error("read answer timing off");
   a_no_read_wait: assert property (disable iff (rst_i)
      !avs_read_i |-> !avs_waitrequest_o) else $error("wait without read");
   a_reset_page: assert property (
      rst_i |=> page_o == `PAGE_RST) else $error("page not zero on reset");
   a_reset_bus: assert property (rst_i |=> avs_readdata_o == 32'h0
      && io_oe_o[31:8] == 24'h0) else $error("bus or enables not reset");
   a_unmapped_zero: assert property (disable iff (rst_i)
      rd_done && avs_address_i > `REG_CAP_CFG |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_status_page: assert property (disable iff (rst_i)
      rd_done && avs_address_i == `REG_STATUS && $stable(page_o)
      |-> avs_readdata_o == {29'h0, page_o}) else $error("status page off");
   a_page_state_bits: assert property (disable iff (rst_i)
      rd_done && avs_address_i == `REG_MC_STATE && $stable(page_o)
      |-> avs_readdata_o[26:24] == page_o) else $error("page bits off");
   a_oe_follows: assert property (disable iff (rst_i)
      avs_write_i && avs_address_i == `REG_MC_OE
      |=> io_oe_o[31:8] == $past(avs_writedata_i[23:0]))
      else $error("enables miss write");
   c_page_moves: cover property (disable iff (rst_i) page_o != $past(page_o));
endmodule

bind paged_array_core paged_array_asserts chk (
   .clk_i            (clk_i),
   .rst_i            (rst_i),
   .avs_address_i    (avs_address_i),
   .avs_read_i       (avs_read_i),
   .avs_write_i      (avs_write_i),
   .avs_writedata_i  (avs_writedata_i),
   .avs_readdata_o   (avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o),
   .io_oe_o          (io_oe_o),
   .page_o           (page_o)
);

// File: testbench/pin_logic_model.sv
// Pin-side model: synchronous board logic around the core's pins.
// Assumes one clock; pins nobody drives carry a level flipping each cycle.
`timescale 1ns/100ps
module pin_logic_model (
   // Clock
   input  wire        clk_i,
   // Core pin outputs
   input  wire [31:0] out_i,
   input  wire [31:0] oe_i,
   // Board drive request
   input  wire [31:0] drive_i,
   input  wire [31:0] drive_en_i,
   // Resolved pin levels
   output wire [31:0] pin_o
);
   reg [31:0] churn_ff = 32'h5a5aa5a5;
   // Floating pins toggle so a stale level never passes for a real one
   always @(posedge clk_i) begin
      churn_ff <= ~churn_ff;
   end
   // Core drive wins, then board drive, then the floating pattern
   assign pin_o = (oe_i & out_i) | (~oe_i & drive_en_i & drive_i)
                | (~oe_i & ~drive_en_i & churn_ff);
endmodule

// File: testbench/tb_top.sv
// Bench of the paged array core driven over its Avalon slave.
// Assumes the pin model beside the core and the checker bound to it.
`timescale 1ns/100ps
`include "paged_array_consts.vh"
module tb_top;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg  [10:0] avs_address_i = 11'h000;
   reg         avs_read_i = 1'b0;
   reg         avs_write_i = 1'b0;
   reg  [31:0] avs_writedata_i = 32'h0;
   reg         ded_in_i = 1'b0;
   reg  [31:0] board_val = 32'h0;
   wire [31:0] avs_readdata_o;
   wire        avs_waitrequest_o;
   wire [31:0] io_in_i;
   wire [31:0] io_out_o;
   wire [31:0] io_oe_o;
   wire [2:0]  page_o;
   integer     n_fail = 0;
   integer     checks_done = 0;
   integer     cyc = 0;
   integer     i;
   integer     p;
   reg  [31:0] q;
   reg  [2:0]  p0;

   // Clock, 25 ns period
   always #12.5 clk_i = ~clk_i;

   paged_array_core DUT (
      .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .io_in_i(io_in_i),
      .io_out_o(io_out_o), .io_oe_o(io_oe_o), .ded_in_i(ded_in_i),
      .page_o(page_o));

   pin_logic_model board (
      .clk_i(clk_i), .out_i(io_out_o), .oe_i(io_oe_o), .drive_i(board_val),
      .drive_en_i(board_val), .pin_o(io_in_i));

   task tally_and_finish;
      begin
         $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
         if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask

   // A hang is cut short well past the expected run length
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_fail = n_fail + 1;
         tally_and_finish;
      end
   end

   // One transfer, entered just after a rising edge; request stays up so
   // back-to-back calls never assign a strobe twice in one time step
   task bus(input wr, input [10:0] a, input [31:0] d);
      reg w;
      begin
         avs_address_i <= a;
         avs_writedata_i <= d;
         avs_write_i <= wr;
         avs_read_i <= ~wr;
         w = 1'b1;
         // Values read here are those of the edge; design updates land later
         while (w) begin
            @(posedge clk_i);
            w = avs_waitrequest_o;
            q = avs_readdata_o;
         end
      end
   endtask

   task idle;
      begin
         avs_write_i <= 1'b0;
         avs_read_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   task chk_reg(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task chk_pin(input [7:0] got, input [7:0] exp);
      chk_reg({24'h0, got}, {24'h0, exp});
   endtask

   // Fixed cells with empty terms: sum is one, enable and clear are one
   task fix_chk(input [31:0] cfg, input [15:0] exp);
      begin
         bus(1'b1, `REG_IOC_CFG, cfg);
         idle;
         @(negedge clk_i);
         chk_pin(io_oe_o[7:0], exp[15:8]);
         if (!cfg[2])
            chk_pin(io_out_o[7:0], exp[7:0]);
         @(posedge clk_i);
      end
   endtask

   // Writable bits of each register from REG_MUX3_SEL to REG_CAP_CFG
   function [31:0] rw_mask(input [3:0] a);
      case (a)
         4'h5: rw_mask = 32'h000000ff;
         4'h6: rw_mask = 32'h07ffffff;
         4'h7, 4'h8: rw_mask = 32'h00ffffff;
         4'h9: rw_mask = 32'h0000ffff;
         default: rw_mask = 32'hffffffff;
      endcase
   endfunction

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (i = 0; i < 12; i = i + 1) begin
         bus(1'b0, (i < 10) ? i[10:0] : 11'h1f6 + i[10:0], 32'h0);
         chk_reg(q, 32'h0);
      end
      $display("test reset_values done");
      for (i = 3; i < 10; i = i + 1) begin
         bus(1'b1, i[10:0], 32'hffffffff);
         bus(1'b0, i[10:0], 32'h0);
         chk_reg(q, rw_mask(i[3:0]));
      end
      chk_reg(io_oe_o & 32'hffffff00, 32'hffffff00);
      bus(1'b1, 11'h0ff, 32'hffffffff);
      bus(1'b0, 11'h0ff, 32'h0);
      chk_reg(q, 32'h0);
      for (i = 3; i < 10; i = i + 1)
         bus(1'b1, i[10:0], 32'h0);
      $display("test register_access done");
      // Page p loads its page cells with p+1 in data-enable mode
      for (p = 0; p < 8; p = p + 1)
         for (i = 0; i < `PAGE_WORDS; i = i + 1)
            bus(1'b1, 11'(`PAGE_BASE + p * `PAGE_WORDS + i), (i < 88) ?
                32'h0 : 32'h00010000 | (((p + 1) >> (i - 88)) & 1));
      for (i = 0; i < `FIX_WORDS; i = i + 1)
         bus(1'b1, 11'(`FIXED_BASE + i), 32'h0);
      bus(1'b1, `REG_CTRL, 32'h1);
      idle;
      @(negedge clk_i);
      p0 = page_o;
      for (i = 1; i < 10; i = i + 1) begin
         @(negedge clk_i);
         chk_pin({5'h0, page_o}, {5'h0, p0 + i[2:0]});
      end
      @(posedge clk_i);
      $display("test page_advance done");
      fix_chk(32'h000000, 16'hffff);
      fix_chk(32'h492492, 16'hff00);
      fix_chk(32'h249249, 16'hff00);
      fix_chk(32'h924924, 16'h0000);
      $display("test fixed_cells done");
      bus(1'b1, `REG_CTRL, 32'h0);
      idle;
      @(negedge clk_i);
      p0 = page_o;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk_pin({5'h0, page_o}, {5'h0, p0});
      @(posedge clk_i);
      bus(1'b0, `REG_STATUS, 32'h0);
      chk_reg(q, {29'h0, p0});
      bus(1'b0, `REG_MC_STATE, 32'h0);
      chk_reg(q, {5'h0, p0, 24'h0});
      idle;
      $display("test page_hold done");
      // Dedicated pin into both arrays: fixed cell 0 sum and macrocell 0
      for (i = 0; i < 8; i = i + 1) begin
         bus(1'b1, 11'(`FIXED_BASE + i * 3 + 1), 32'h00008000);
         if (i > 0)
            bus(1'b1, 11'(`FIXED_BASE + i * 3 + 2), 32'h80000000);
      end
      for (p = 0; p < 8; p = p + 1) begin
         bus(1'b1, 11'(`PAGE_BASE + p * `PAGE_WORDS + 5), 32'h80000000);
         bus(1'b1, 11'(`PAGE_BASE + p * `PAGE_WORDS + 64), 32'h00010002);
      end
      bus(1'b1, `REG_IOC_CFG, 32'h0);
      bus(1'b1, `REG_CTRL, 32'h1);
      for (i = 0; i < 2; i = i + 1) begin
         ded_in_i <= ~i[0];
         idle;
         repeat (3) @(posedge clk_i);
         @(negedge clk_i);
         chk_pin({6'h0, io_out_o[8], io_out_o[0]}, {6'h0, {2{~i[0]}}});
         @(posedge clk_i);
      end
      $display("test pin_routing done");
      tally_and_finish;
   end
endmodule
